//--- hdl/ssx_engine.sv
// Clock-synchronous 8-bit serial transfer engine with its register port.
// Assumes a plain register master on mclk and a peer on the pins.
//
// Contract
// - start shifts buffer out LSB first
// - load into shifter empties buffer, raises interrupt
// - internal clock halts when no next byte
// - serial out keeps last bit until first fall
// - clearing start finishes byte then drops active
// - abort stops at once, drops active
// - external clock late stop sends one dummy byte
// - receive LSB first, buffer full interrupt
// - internal clock receive waits for buffer read
// - clearing start during receive completes byte
// - abort during receive stops, data invalid
// - mode change discards buffer contents
// - duplex drives on fall, samples on rise
// - internal duplex waits for read and write
// - clearing start in duplex completes byte
// - internal clock pin starts high
// - select 111 uses the external clock
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module ssx_engine (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Register port.
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Interrupt request, one-cycle pulse.
    output logic            serial_irq,
    // Serial clock pin, two-way.
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    // Serial data pins.
    input  wire logic       si_in,
    output logic            so_out
);
    import ssx_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        ssx_st_t          st;       // Engine state.
        logic             start;    // Start control.
        logic [1:0]       mode;     // Transfer mode select.
        logic [2:0]       rate;     // Clock rate select.
        logic [7:0]       dbuf;     // Shared data buffer.
        logic             tx_full;  // Buffer holds a fresh byte.
        logic             rx_full;  // Buffer holds an unread byte.
        logic [7:0]       sh;       // Shift register.
        logic [3:0]       cnt;      // Bits done in this byte.
        logic             so;       // Serial out level.
        logic             sck;      // Internal clock level.
        logic [DIV_W-1:0] div;      // Half period counter.
        logic             active;   // Transfer active flag.
        logic             last;     // Stop after this byte.
        logic             begun;    // A fall has opened this byte.
        logic             irq;      // Interrupt pulse.
        logic [7:0]       rdata;    // Read data.
    } ssx_state_t;

    ssx_state_t s;       // Registered state.
    ssx_state_t next_s;  // Next state.

    logic ext;     // External clock selected.
    logic tick;    // Divider reached its end.
    logic fall;    // Falling serial clock edge this cycle.
    logic rise;    // Rising serial clock edge this cycle.
    logic e_fall;  // Pin falling edge.
    logic e_rise;  // Pin rising edge.
    logic si_s;    // Synchronised data input.

    // ==========================================
    // Helpers

    // True for the modes that drive serial out.
    function automatic logic tx_on(input logic [1:0] m);
        return m != MODE_RX;
    endfunction

    // True for the modes that take serial in into the buffer.
    function automatic logic rx_on(input logic [1:0] m);
        return m != MODE_TX;
    endfunction

    // Reload value of the half period divider for a rate select.
    function automatic logic [DIV_W-1:0] half(input logic [2:0] r);
        logic [3:0] sh_by;
        sh_by = {1'b0, r} + DIV_BASE;
        return (10'h001 << sh_by) - 10'h001;
    endfunction

    // ==========================================
    // Pin synchroniser

    // Both pins cross into mclk before any logic reads them.
    ssx_pin_sync u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .sck_in   (sck_in),
        .si_in    (si_in),
        .sck_fall (e_fall),
        .sck_rise (e_rise),
        .si_s     (si_s)
    );

    // ==========================================
    // Next state

    // Bus accesses first, then one step of the shift engine.
    always_comb begin
        next_s       = s;
        next_s.irq   = 1'b0;
        next_s.rdata = 8'h00;
        ext  = (s.rate == RATE_EXT);
        tick = (s.div == '0);
        // Edges come from the pin or from the own divider.
        if (ext) begin
            fall = e_fall;
            rise = e_rise;
        end else begin
            fall = tick & s.sck;
            rise = tick & ~s.sck;
        end

        // Register reads; data stand in the next cycle only.
        if (rd) begin
            if (addr == ADDR_CTRL) begin
                next_s.rdata = {s.start, 1'b0, s.mode, 1'b1, s.rate};
            end else if (addr == ADDR_BUF) begin
                // Reading the buffer frees it for the next byte.
                next_s.rdata   = s.dbuf;
                next_s.rx_full = 1'b0;
            end else if (addr == ADDR_STAT) begin
                next_s.rdata           = STAT_FILL;
                next_s.rdata[STAT_ACT] = s.active;
                next_s.rdata[STAT_SHF] = (s.st == SSX_SHIFT);
            end else begin
                // Unmapped offsets read as zero.
                next_s.rdata = 8'h00;
            end
        end

        // Register writes.
        if (wr) begin
            if (addr == ADDR_CTRL) begin
                next_s.start = wdata[CTL_START];
                next_s.rate  = wdata[2:0];
                // A new mode throws away whatever the buffer held.
                if (wdata[CTL_MODE+:2] != s.mode) begin
                    next_s.mode    = wdata[CTL_MODE+:2];
                    next_s.dbuf    = BUF_RST;
                    next_s.tx_full = 1'b0;
                    next_s.rx_full = 1'b0;
                end
                if (wdata[CTL_ABORT]) begin
                    // Abort drops the transfer at once; the buffer keeps its value, start takes the written bit.
                    next_s.st     = SSX_IDLE;
                    next_s.active = 1'b0;
                    next_s.sck    = 1'b1;
                    next_s.cnt    = 4'h0;
                end else if (wdata[CTL_START] && s.st == SSX_IDLE &&
                             wdata[CTL_MODE+:2] != MODE_RSV) begin
                    // A start in the reserved mode is ignored.
                    next_s.st     = SSX_SHIFT;
                    next_s.active = 1'b1;
                    next_s.cnt    = 4'h0;
                    next_s.sck    = 1'b1;
                    next_s.div    = half(wdata[2:0]);
                    next_s.last   = 1'b0;
                    next_s.begun  = 1'b0;
                end
            end else if (addr == ADDR_BUF) begin
                // A write fills the buffer for transmission.
                next_s.dbuf    = wdata;
                next_s.tx_full = 1'b1;
            end
        end

        // Shift engine; skipped in a cycle that starts or aborts.
        if (s.active && next_s.active) begin
            case (s.st)
                SSX_SHIFT: begin
                    // Start cleared between bytes ends the transfer.
                    if (!s.begun && !next_s.start && !fall) begin
                        next_s.st     = SSX_IDLE;
                        next_s.active = 1'b0;
                    end
                    // Own divider runs only while shifting.
                    if (!ext) begin
                        next_s.div = tick ? half(s.rate) : s.div - 1'b1;
                    end
                    if (fall) begin
                        next_s.begun = 1'b1;
                        if (!ext) begin
                            next_s.sck = 1'b0;
                        end
                        if (tx_on(s.mode) && s.cnt == 4'h0) begin
                            // First fall of a byte moves it in.
                            next_s.sh      = next_s.dbuf;
                            next_s.so      = next_s.dbuf[0];
                            next_s.tx_full = 1'b0;
                            // An empty buffer here means a dummy byte.
                            if (ext && !next_s.tx_full) begin
                                next_s.last = !s.tx_full;
                            end
                            if (s.mode == MODE_TX) begin
                                next_s.irq = 1'b1;
                            end
                        end else if (tx_on(s.mode)) begin
                            // Later bits go out on the fall too.
                            next_s.so = s.sh[0];
                        end
                    end
                    if (rise) begin
                        if (!ext) begin
                            next_s.sck = 1'b1;
                        end
                        // Sample on the rise, LSB arrives first.
                        next_s.sh  = {si_s, s.sh[7:1]};
                        next_s.cnt = s.cnt + 4'h1;
                        if (s.cnt == BIT_LAST) begin
                            next_s.cnt = 4'h0;
                            next_s.begun = 1'b0;
                            if (rx_on(s.mode)) begin
                                // Whole byte goes to the buffer.
                                next_s.dbuf    = {si_s, s.sh[7:1]};
                                next_s.rx_full = 1'b1;
                                next_s.tx_full = 1'b0;
                                next_s.irq     = 1'b1;
                            end
                            if (!next_s.start || s.last) begin
                                // Stop only once the byte is complete.
                                next_s.st     = SSX_IDLE;
                                next_s.active = 1'b0;
                            end else if (!ext) begin
                                // Own clock waits for software.
                                next_s.st = SSX_HOLD;
                            end
                        end
                    end
                end
                SSX_HOLD: begin
                    // Clock rests high while software catches up.
                    if (!next_s.start) begin
                        next_s.st     = SSX_IDLE;
                        next_s.active = 1'b0;
                    end else if (
                        (s.mode == MODE_TX && next_s.tx_full) ||
                        (s.mode == MODE_RX && !next_s.rx_full) ||
                        (s.mode == MODE_FD && !next_s.rx_full &&
                         next_s.tx_full)) begin
                        next_s.st  = SSX_SHIFT;
                        next_s.div = half(s.rate);
                    end
                end
                default: begin
                    // Idle holds no work.
                    next_s.st = SSX_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s         <= '0;
            s.st      <= SSX_IDLE;
            s.mode    <= MODE_RST;
            s.rate    <= RATE_RST;
            s.dbuf    <= BUF_RST;
            s.sck     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // Outputs
    assign rdata      = s.rdata;
    assign serial_irq = s.irq;
    assign sck_out    = s.sck;
    assign sck_oe     = (s.rate != RATE_EXT);
    assign so_out     = s.so;

    // ==========================================
    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // A start in the reserved mode leaves the engine idle.
    rsv_mode_a: assert property (
        wr && addr == ADDR_CTRL && !s.active &&
        wdata[CTL_MODE+:2] == MODE_RSV |=> !s.active)
        else $error("reserved mode started a transfer");

    // In transmit mode, moving a byte into the shifter raises the interrupt.
    tx_irq_a: assert property (
        s.st == SSX_SHIFT && s.active && fall && s.cnt == 4'h0 &&
        s.mode == MODE_TX && !wr |=> serial_irq && !s.tx_full)
        else $error("no interrupt on transmit load");

    // The own clock rests high in the wait state.
    hold_sck_a: assert property (
        s.st == SSX_HOLD && !ext |-> sck_out)
        else $error("clock not high while waiting");

    // Serial out keeps its old level when a transfer starts.
    so_keep_a: assert property (
        $rose(s.active) |-> so_out == $past(so_out))
        else $error("serial out moved at start");

    // Abort drops the active flag at the next edge.
    abort_a: assert property (
        wr && addr == ADDR_CTRL && wdata[CTL_ABORT]
        |=> !s.active && s.st == SSX_IDLE)
        else $error("abort did not stop the transfer");

    // The eighth rise fills the buffer and signals it.
    rx_store_a: assert property (
        s.st == SSX_SHIFT && s.active && rise && s.cnt == BIT_LAST &&
        rx_on(s.mode) && !wr |=> s.rx_full && serial_irq)
        else $error("received byte not stored");

    // Receive with own clock stays put until the byte is read.
    rx_wait_a: assert property (
        s.st == SSX_HOLD && s.mode == MODE_RX && s.rx_full &&
        !rd && !wr |=> s.st == SSX_HOLD && s.rx_full)
        else $error("receive left wait without a read");

    // Later bits go out on the fall from the shifter bottom.
    so_edge_a: assert property (
        s.st == SSX_SHIFT && s.active && fall && s.cnt != 4'h0 &&
        tx_on(s.mode) && !wr |=> so_out == $past(s.sh[0]))
        else $error("serial out not from shifter");

    // A cleared start ends the transfer with the byte.
    stop_a: assert property (
        s.st == SSX_SHIFT && s.active && rise && s.cnt == BIT_LAST &&
        !s.start && !wr |=> !s.active ##1 (!s.active || $past(wr)))
        else $error("transfer ran past a cleared start");

    // The own clock stands high while idle.
    idle_high_a: assert property (
        !ext && s.st == SSX_IDLE |-> sck_out)
        else $error("clock pin low while idle");

    // The external clock select releases the pin.
    ext_oe_a: assert property (
        s.rate == RATE_EXT |-> !sck_oe)
        else $error("clock driven in external mode");

endmodule // ssx_engine

//--- inc/ssx_pkg.sv
// Constants and types shared by the synchronous serial transfer engine.
// Assumes an 8-bit register port with a two-bit address.
package ssx_pkg;

    // ==========================================
    // Register offsets
    localparam logic [1:0] ADDR_CTRL = 2'h0;  // Control register.
    localparam logic [1:0] ADDR_BUF  = 2'h1;  // Shared data buffer.
    localparam logic [1:0] ADDR_STAT = 2'h3;  // Status register.

    // ==========================================
    // Control field positions
    localparam int CTL_START = 7;  // Start bit.
    localparam int CTL_ABORT = 6;  // Abort bit, reads as zero.
    localparam int CTL_MODE  = 4;  // Low bit of the two-bit mode.
    localparam int CTL_ONE   = 3;  // Bit that always reads as one.

    // ==========================================
    // Status field positions and fill value
    localparam int         STAT_ACT  = 3;      // Transfer active.
    localparam int         STAT_SHF  = 2;      // Shift in progress.
    localparam logic [7:0] STAT_FILL = 8'hF3;  // Unused bits read one.

    // ==========================================
    // Transfer modes and clock select
    localparam logic [1:0] MODE_TX  = 2'h0;  // Transmit only.
    localparam logic [1:0] MODE_RSV = 2'h1;  // Reserved.
    localparam logic [1:0] MODE_FD  = 2'h2;  // Transmit and receive.
    localparam logic [1:0] MODE_RX  = 2'h3;  // Receive only.
    localparam logic [2:0] RATE_EXT = 3'h7;  // Clock from the pin.

    // ==========================================
    // Reset values
    localparam logic [1:0] MODE_RST = 2'h0;  // Mode after reset.
    localparam logic [2:0] RATE_RST = 3'h0;  // Clock select after reset.
    localparam logic [7:0] BUF_RST  = 8'h00; // Buffer after reset.

    // ==========================================
    // Timing
    localparam int         CLK_MHZ   = 200;   // Core clock rate.
    localparam logic [3:0] BIT_LAST  = 4'h7;  // Index of the last bit.
    localparam logic [3:0] DIV_BASE  = 4'h3;  // Half period is 2^(sel+3).
    localparam int         DIV_W     = 10;    // Divider width.

    // ==========================================
    // Engine states
    typedef enum logic [1:0] {
        SSX_IDLE,
        SSX_SHIFT,
        SSX_HOLD
    } ssx_st_t;

endpackage

//--- hdl/ssx_pin_sync.sv
// Synchroniser and edge finder for the serial clock and data input pins.
// Assumes both pins are asynchronous to mclk.
`timescale 1ns/1ps
module ssx_pin_sync (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Raw pins.
    input  wire logic sck_in,
    input  wire logic si_in,
    // Clean outputs.
    output logic      sck_fall,
    output logic      sck_rise,
    output logic      si_s
);

    // ==========================================
    // State
    typedef struct packed {
        logic sck_a;  // First stage, read only by the second.
        logic sck_b;  // Second stage.
        logic sck_c;  // Delayed copy for edge finding.
        logic si_a;   // First stage of the data pin.
        logic si_b;   // Second stage of the data pin.
    } ssx_sync_t;

    ssx_sync_t s;       // Registered state.
    ssx_sync_t next_s;  // Next state.

    // Shift each pin along its chain.
    always_comb begin
        next_s       = s;
        next_s.sck_a = sck_in;
        next_s.sck_b = s.sck_a;
        next_s.sck_c = s.sck_b;
        next_s.si_a  = si_in;
        next_s.si_b  = s.si_a;
    end

    // Register the chains; the clock idles high.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s <= 5'h1F;
        end else begin
            s <= next_s;
        end
    end

    // Edges are seen between the second and third stages.
    assign sck_fall = s.sck_c & ~s.sck_b;
    assign sck_rise = ~s.sck_c & s.sck_b;
    assign si_s     = s.si_b;

endmodule // ssx_pin_sync

//--- tb/ssx_peer_model.sv
// Behavioural serial peer on the far side of the transfer engine.
// Assumes the bench resolves the two-way clock pin into sck.
`timescale 1ns/1ps
module ssx_peer_model (
    // Resolved pins.
    input  wire logic       sck,
    input  wire logic       so,
    output logic            si,
    output logic            sck_drv,
    // Frame data and bookkeeping.
    input  wire logic [7:0] tx_byte,
    input  wire logic       clr,
    output logic      [7:0] rx_byte,
    output int              rises
);
    // ==========================================
    // Frame state
    int bit_idx;  // Next bit position.

    // Clock idles high; the bus is quiet at start.
    initial begin
        si      = 1'b0;
        sck_drv = 1'b1;
        rx_byte = 8'h00;
        rises   = 0;
        bit_idx = 0;
    end

    // A new frame starts counting from bit zero.
    always @(posedge clr) begin
        bit_idx = 0;
        rises   = 0;
    end

    // Drive on falls; outside a frame the line toggles, not holds.
    always @(negedge sck) begin
        if (bit_idx < 8) begin
            si <= tx_byte[bit_idx[2:0]];
        end else begin
            si <= ~si;
        end
    end

    // Catch the engine's bits on rises, LSB first.
    always @(posedge sck) begin
        if (bit_idx < 8) begin
            rx_byte[bit_idx[2:0]] = so;
            bit_idx = bit_idx + 1;
        end
        rises = rises + 1;
    end

    // One frame of eight clock pulses, 48 ns each.
    task automatic ext_frame();
        repeat (8) begin
            #24 sck_drv = 1'b0;
            #24 sck_drv = 1'b1;
        end
    endtask
endmodule  // ssx_peer_model

//--- tb/tb_top.sv
// Self-checking bench for the serial transfer engine.
// Assumes the peer model and the engine share one resolved clock pin.
`timescale 1ns/1ps
module tb_top;
    import ssx_pkg::*;
    // ==========================================
    // Signals
    logic       mclk, sys_rst, wr, rd, clr;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, tx_byte, rx_byte, d;
    logic       serial_irq, sck_out, sck_oe, si, so, sck_drv, sck;
    int         rises, failures, check_count;

    // The engine owns the pin while its enable is high.
    assign sck = sck_oe ? sck_out : sck_drv;

    ssx_engine uut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .serial_irq(serial_irq), .sck_in(sck), .sck_out(sck_out),
        .sck_oe(sck_oe), .si_in(si), .so_out(so));
    ssx_peer_model u_peer (.sck(sck), .so(so), .si(si),
        .sck_drv(sck_drv), .tx_byte(tx_byte), .clr(clr),
        .rx_byte(rx_byte), .rises(rises));

    // ==========================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // One-cycle read; data is taken in the cycle after the strobe.
    task automatic rd_reg(input logic [1:0] a);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Interrupt is a one-cycle pulse; give up after a bound.
    task automatic wait_irq();
        int n;
        n = 0;
        @(posedge mclk);
        while (serial_irq !== 1'b1) begin
            n++;
            if (n > 600) begin
                failures++;
                final_report();
            end
            @(posedge mclk);
        end
    endtask

    // Wait until the peer has seen n clock rises.
    task automatic wait_rises(input int n);
        int k;
        for (k = 0; k < 800 && rises < n; k++) @(posedge mclk);
        if (rises < n) begin
            failures++;
            final_report();
        end
    endtask

    // Restart the peer's frame count.
    task automatic pulse_clr();
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs();
        rd_reg(ADDR_CTRL);
        check(d, 8'h08);
        rd_reg(ADDR_STAT);
        check(d, STAT_FILL);
        rd_reg(2'h2);
        check(d, 8'h00);
        wr_reg(ADDR_CTRL, 8'h90);
        rd_reg(ADDR_STAT);
        check(d, STAT_FILL);
    endtask

    // Internal clock transmit: hold, resume, then stop after the byte.
    task automatic t_tx();
        pulse_clr();
        wr_reg(ADDR_CTRL, 8'h00);
        wr_reg(ADDR_BUF, 8'hA5);
        wr_reg(ADDR_CTRL, 8'h80);
        wait_irq();
        wait_rises(8);
        check(rx_byte, 8'hA5);
        repeat (40) @(posedge mclk);
        check(8'(rises), 8'h08);
        check({7'h00, sck_out}, 8'h01);
        rd_reg(ADDR_STAT);
        check(d & 8'h08, 8'h08);
        pulse_clr();
        wr_reg(ADDR_BUF, 8'h3C);
        wait_irq();
        wr_reg(ADDR_CTRL, 8'h00);
        wait_rises(8);
        check(rx_byte, 8'h3C);
        repeat (40) @(posedge mclk);
        rd_reg(ADDR_STAT);
        check(d, STAT_FILL);
    endtask

    // Start then abort before the first fall; output keeps the old bit.
    task automatic t_abort();
        pulse_clr();
        wr_reg(ADDR_BUF, 8'h01);
        wr_reg(ADDR_CTRL, 8'h80);
        repeat (2) @(posedge mclk);
        check({7'h00, so}, 8'h00);
        check({6'h00, sck_oe, sck_out}, 8'h03);
        wr_reg(ADDR_CTRL, 8'hC0);
        rd_reg(ADDR_STAT);
        check(d, STAT_FILL);
        repeat (40) @(posedge mclk);
        check(8'(rises), 8'h00);
    endtask

    // Internal clock receive: hold without a read, stop by clearing start, then read the byte.
    task automatic t_rx();
        wr_reg(ADDR_CTRL, 8'h30);
        tx_byte <= 8'hC6;
        pulse_clr();
        wr_reg(ADDR_CTRL, 8'hB0);
        wait_irq();
        repeat (40) @(posedge mclk);
        check(8'(rises), 8'h08);
        wr_reg(ADDR_CTRL, 8'h30);
        rd_reg(ADDR_STAT);
        check(d, STAT_FILL);
        rd_reg(ADDR_BUF);
        check(d, 8'hC6);
    endtask

    // External clock full duplex at the link rate.
    task automatic t_duplex();
        wr_reg(ADDR_CTRL, 8'h27);
        @(posedge mclk);
        check({7'h00, sck_oe}, 8'h00);
        wr_reg(ADDR_BUF, 8'h96);
        tx_byte <= 8'h5A;
        pulse_clr();
        wr_reg(ADDR_CTRL, 8'hA7);
        fork
            u_peer.ext_frame();
            wait_irq();
        join
        rd_reg(ADDR_BUF);
        check(d, 8'h5A);
        check(rx_byte, 8'h96);
        wr_reg(ADDR_CTRL, 8'h27);
        rd_reg(ADDR_STAT);
        check(d, STAT_FILL);
    endtask

    // ==========================================
    // Clock and main sequence
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        sys_rst     = 1'b1;
        wr          = 1'b0;
        rd          = 1'b0;
        clr         = 1'b0;
        addr        = 2'h0;
        wdata       = 8'h00;
        tx_byte     = 8'h00;
        failures    = 0;
        check_count = 0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_tx();
        t_abort();
        t_rx();
        t_duplex();
        final_report();
    end
endmodule  // tb_top
